// ==== logic/ttg_consts.svh ====
// constants of the time-triggered edge generator pair
// assumes one 125 MHz clock shared with the time engine
//
// Operation
// RULE1: software sets a reference before relative commands
// RULE2: relative events offset from the previous event
// RULE3: fine bit makes relative units 1/256 ns
// RULE4: software keeps fine bit during repeat groups
// RULE5: reset empties queue, clears sequencer, output low
// RULE6: advance-disable finishes group, blocks next command; here an active group keeps looping while it is set
// RULE7: software sets advance-disable while loading groups
// RULE8: live unlatched queue-full bit per generator
// RULE9: software avoids writing to a full queue
// RULE10: separate write-only queue port per generator
// RULE11: repeat periods in 2 ns or 2/256 ns steps
// RULE12: set-reference 0x20000, repeat N in low bits
// RULE13: toggle code E, two words for 32-bit time
// RULE14: absolute rising edge takes five words, code 5
// RULE15: fractional repeats interleave sixteenths of both counts
// RULE16: fractional counts are met exactly every cycle
// RULE17: relative edge at least 16 ns after previous
// RULE18: fastest periodic output is quarter reference rate
// RULE19: bits 19:18 pick action, 17:16 pick format
// RULE20: 16-bit relative command is one word
// RULE21: fractional counts in bits 15:8 and 7:0
// RULE22: edge placed when current time reaches event
// RULE23: both generators run fully independently
`ifndef TTG_CONSTS_SVH
`define TTG_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TTG_OFS_CTRL   12'h000
`define TTG_OFS_STAT   12'h004
`define TTG_OFS_QUE1   12'h008
`define TTG_OFS_QUE2   12'h00C
`define TTG_CTRL_W     6
`define TTG_CTRL_RST   6'h00
`define TTG_B_FINE1    0
`define TTG_B_FINE2    1
`define TTG_B_RST1     2
`define TTG_B_RST2     3
`define TTG_B_DIS1     4
`define TTG_B_DIS2     5

// ----------------------------------------------------------------
// command word
// ----------------------------------------------------------------
`define TTG_WORD_W     20
`define TTG_CMD_HI     19
`define TTG_CMD_LO     16
`define TTG_ACT_NONE   2'h0
`define TTG_ACT_RISE   2'h1
`define TTG_ACT_FALL   2'h2
`define TTG_ACT_TOGG   2'h3
`define TTG_FMT_REPEAT 2'h0
`define TTG_FMT_FRAC   2'h1
`define TTG_FMT_SETREF 2'h2
`define TTG_FMT_ABS    2'h1
`define TTG_FMT_REL32  2'h2
`define TTG_FMT_REL16  2'h3

// ----------------------------------------------------------------
// queue and timing
// ----------------------------------------------------------------
`define TTG_QADDR_W    4
`define TTG_PTR_W      5
`define TTG_PTR_ONE    5'h01
`define TTG_QDEPTH     5'h10
`define TTG_GROUP_MAX  5'h08
`define TTG_FRAC_ENT   5'h04
`define TTG_FRAC_HALF  5'h02
`define TTG_NF_PER_SEC 38'h3B9ACA0000
`define TTG_CLK_NS     8
`define TTG_MIN_GAP_NS 16
`define TTG_MIN_GAP_CYC ((`TTG_MIN_GAP_NS + `TTG_CLK_NS - 1) / `TTG_CLK_NS)

`endif

// ==== logic/ttg_pkg.sv ====
// types of the time-triggered edge generator pair
// assumes ttg_consts.svh is on the include path
`include "ttg_consts.svh"

package ttg_pkg;

  typedef enum logic [1:0] {
    TTG_ST_FETCH = 2'b01,
    TTG_ST_WAIT  = 2'b10
  } ttg_state_e;

  typedef logic [`TTG_PTR_W-1:0] ttg_ptr_t;

  typedef struct packed {
    ttg_state_e  st;
    logic        out;
    ttg_ptr_t    wp;
    ttg_ptr_t    rp;
    ttg_ptr_t    fp;
    logic        data_ok;
    logic [1:0]  act;
    logic [1:0]  fmt;
    logic [2:0]  wcnt;
    logic [47:0] acc_sec;
    logic [29:0] acc_ns;
    logic [47:0] evt_sec;
    logic [37:0] evt_nf;
    logic        grp_act;
    logic        grp_frac;
    ttg_ptr_t    grp_start;
    ttg_ptr_t    grp_end;
    logic [7:0]  m1;
    logic [7:0]  m2;
    logic [7:0]  ra;
    logic [7:0]  rb;
    logic [3:0]  chunk;
    logic        half;
  } ttg_gen_s;

  typedef struct packed {
    logic [`TTG_CTRL_W-1:0] ctrl;
    logic [31:0]            rdata;
  } ttg_top_s;

endpackage

// ==== logic/ttg_queue_mem.sv ====
// command queue storage of one generator
// assumes one writer and one reader on pclk, registered read data
`timescale 1ns/1ps

module ttg_queue_mem #(
  parameter int WIDTH  = 20,
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // write side
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  // read side
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem [2**ADDR_W];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ==== logic/ttg_top.sv ====
// two time-triggered edge generators behind an APB slave
// assumes the time engine runs on pclk and presents sec/ns/frac
`timescale 1ns/1ps
`include "ttg_consts.svh"

// ----------------------------------------------------------------
// one generator: queue, sequencer, output
// ----------------------------------------------------------------
module ttg_gen
  import ttg_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // control
  input  wire logic                   soft_rst,
  input  wire logic                   fine,
  input  wire logic                   adv_dis,
  // queue write
  input  wire logic                   wr_en,
  input  wire logic [`TTG_WORD_W-1:0] wr_data,
  // time engine
  input  wire logic [47:0]            cur_sec,
  input  wire logic [29:0]            cur_ns,
  input  wire logic [7:0]             cur_frac,
  // status and output
  output logic                        queue_full,
  output logic                        edge_out
);

  localparam ttg_gen_s GEN_RST = '{st: TTG_ST_FETCH, default: '0};

  ttg_gen_s                 s_q;
  ttg_gen_s                 s_d;
  logic [`TTG_WORD_W-1:0]   rd_word;
  logic [1:0]               act;
  logic [1:0]               fmt;
  logic                     avail;
  logic                     full;
  logic                     wr_ok;
  logic                     go;
  logic                     reached;
  logic                     leave;
  ttg_ptr_t                 p1;
  logic                     consumed;
  logic                     entered;
  logic                     pass_end;
  logic                     frac_sel;
  logic [7:0]               fm1;
  logic [7:0]               fm2;
  logic [7:0]               ra_n;
  logic [7:0]               rb_n;
  logic [3:0]               k_n;

  // repetitions of one sixteenth chunk k of count m
  function automatic logic [7:0] chunk_cnt(input logic [7:0] m, input logic [3:0] k);
    logic [11:0] hi;
    logic [11:0] lo;
    hi = {4'h0, m} * ({8'h00, k} + 12'h001);
    lo = {4'h0, m} * {8'h00, k};
    chunk_cnt = hi[11:4] - lo[11:4];
  endfunction

  // next chunk after k holding any repetition
  function automatic logic [3:0] find_chunk(input logic [3:0] k, input logic [7:0] m1,
                                            input logic [7:0] m2);
    logic [3:0] kk;
    logic       found;
    found = 1'b0;
    find_chunk = k;
    for (int j = 1; j <= 16; j++) begin
      kk = k + 4'(j);
      if (!found && ((chunk_cnt(m1, kk) != 8'h00) || (chunk_cnt(m2, kk) != 8'h00))) begin
        find_chunk = kk;
        found = 1'b1;
      end
    end
  endfunction

  // event time plus relative offset, carrying into seconds
  function automatic logic [85:0] add_rel(input logic [47:0] sec, input logic [37:0] nf,
                                          input logic [29:0] val, input logic fin);
    logic [37:0] off;
    logic [38:0] sum;
    logic [38:0] wrap;
    off = fin ? {8'h00, val} : {val, 8'h00};
    sum = {1'b0, nf} + {1'b0, off};
    wrap = sum - {1'b0, `TTG_NF_PER_SEC};
    if (sum >= {1'b0, `TTG_NF_PER_SEC}) begin
      add_rel = {sec + 48'h1, wrap[37:0]};
    end else begin
      add_rel = {sec, sum[37:0]};
    end
  endfunction

  ttg_queue_mem #(
    .WIDTH  (`TTG_WORD_W),
    .ADDR_W (`TTG_QADDR_W)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (wr_ok),
    .waddr   (s_q.wp[`TTG_QADDR_W-1:0]),
    .wdata   (wr_data),
    .raddr   (s_q.rp[`TTG_QADDR_W-1:0]),
    .rdata   (rd_word)
  );

  assign act        = rd_word[`TTG_CMD_HI:`TTG_CMD_HI-1];    // see RULE19
  assign fmt        = rd_word[`TTG_CMD_LO+1:`TTG_CMD_LO];
  assign avail      = s_q.rp != s_q.wp;
  assign full       = (s_q.wp - s_q.fp) == `TTG_QDEPTH;
  assign wr_ok      = wr_en && !full;
  assign p1         = s_q.rp + `TTG_PTR_ONE;
  assign leave      = (s_q.wp != (s_q.grp_end + `TTG_PTR_ONE)) && !adv_dis;
  // a new command may start only when advance is enabled; see RULE6
  assign go         = avail && s_q.data_ok && (!adv_dis || s_q.grp_act || (s_q.wcnt != 3'h0));
  assign reached    = {cur_sec, cur_ns, cur_frac} >= {s_q.evt_sec, s_q.evt_nf};    // see RULE22
  assign queue_full = full;    // see RULE8
  assign edge_out   = s_q.out;

  always_comb begin
    s_d      = s_q;
    consumed = 1'b0;
    entered  = 1'b0;
    pass_end = 1'b0;
    frac_sel = 1'b0;
    fm1      = s_q.m1;
    fm2      = s_q.m2;
    ra_n     = s_q.ra;
    rb_n     = s_q.rb;
    k_n      = s_q.chunk;
    if (wr_ok) begin
      s_d.wp = s_q.wp + `TTG_PTR_ONE;
    end
    case (s_q.st)
      // fetch decodes the word at rp in the cycle after an edge; see RULE17
      TTG_ST_FETCH: begin
        if (go) begin
          consumed = 1'b1;
          if (s_q.wcnt != 3'h0) begin
            s_d.wcnt = s_q.wcnt + 3'h1;
            if (s_q.fmt == `TTG_FMT_REL32) begin
              // second word carries ns[15:0]; see RULE13
              {s_d.evt_sec, s_d.evt_nf} = add_rel(s_q.evt_sec, s_q.evt_nf,
                                                  {s_q.acc_ns[29:16], rd_word[15:0]}, fine);
              s_d.wcnt = 3'h0;
              s_d.st   = TTG_ST_WAIT;
            end else begin
              // words two to five of an absolute time; see RULE14
              case (s_q.wcnt)
                3'h1: begin
                  s_d.acc_sec[31:16] = rd_word[15:0];
                end
                3'h2: begin
                  s_d.acc_sec[15:0] = rd_word[15:0];
                end
                3'h3: begin
                  s_d.acc_ns[29:16] = rd_word[13:0];
                end
                default: begin
                  s_d.evt_sec = s_q.acc_sec;
                  s_d.evt_nf  = {s_q.acc_ns[29:16], rd_word[15:0], 8'h00};
                  s_d.wcnt    = 3'h0;
                  s_d.st      = TTG_ST_WAIT;
                end
              endcase
            end
          end else begin
            s_d.act = act;
            s_d.fmt = fmt;
            if (act == `TTG_ACT_NONE) begin
              case (fmt)
                // repeat the previous N entries; see RULE12
                `TTG_FMT_REPEAT: begin
                  if ((rd_word[15:5] == 11'h000) && (rd_word[4:0] != 5'h00) &&
                      (rd_word[4:0] <= `TTG_GROUP_MAX) && ((s_q.rp - s_q.fp) >= rd_word[4:0])) begin
                    entered       = 1'b1;
                    s_d.grp_act   = 1'b1;
                    s_d.grp_frac  = 1'b0;
                    s_d.grp_start = s_q.rp - rd_word[4:0];
                    s_d.grp_end   = s_q.rp;
                  end
                end
                // fractional repeat over the previous four entries; see RULE21
                `TTG_FMT_FRAC: begin
                  fm1 = rd_word[15:8];
                  fm2 = rd_word[7:0];
                  if (((fm1 | fm2) != 8'h00) && ((s_q.rp - s_q.fp) >= `TTG_FRAC_ENT)) begin
                    entered       = 1'b1;
                    frac_sel      = 1'b1;
                    s_d.grp_act   = 1'b1;
                    s_d.grp_frac  = 1'b1;
                    s_d.grp_start = s_q.rp - `TTG_FRAC_ENT;
                    s_d.grp_end   = s_q.rp;
                    s_d.m1        = fm1;
                    s_d.m2        = fm2;
                    ra_n          = 8'h00;
                    rb_n          = 8'h00;
                    k_n           = 4'hF;
                  end
                end
                // reference point is the current time; see RULE12
                `TTG_FMT_SETREF: begin
                  s_d.evt_sec = cur_sec;
                  s_d.evt_nf  = {cur_ns, cur_frac};
                end
                default: begin
                end
              endcase
            end else begin
              case (fmt)
                `TTG_FMT_ABS: begin
                  s_d.acc_sec[47:32] = rd_word[15:0];    // see RULE14
                  s_d.wcnt           = 3'h1;
                end
                `TTG_FMT_REL32: begin
                  s_d.acc_ns[29:16] = rd_word[13:0];    // see RULE13
                  s_d.wcnt          = 3'h1;
                end
                `TTG_FMT_REL16: begin
                  // offset from the previous event, units by fine bit; see RULE2, RULE3, RULE20
                  {s_d.evt_sec, s_d.evt_nf} = add_rel(s_q.evt_sec, s_q.evt_nf,
                                                      {14'h0000, rd_word[15:0]}, fine);
                  s_d.st = TTG_ST_WAIT;
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
      TTG_ST_WAIT: begin
        if (reached) begin
          // two toggles per period give 2 ns steps and a 32 ns floor; see RULE11, RULE18
          case (s_q.act)
            `TTG_ACT_RISE: begin
              s_d.out = 1'b1;
            end
            `TTG_ACT_FALL: begin
              s_d.out = 1'b0;
            end
            `TTG_ACT_TOGG: begin
              s_d.out = ~s_q.out;
            end
            default: begin
            end
          endcase
          s_d.st = TTG_ST_FETCH;
        end
      end
      default: begin
        s_d.st = TTG_ST_FETCH;
      end
    endcase

    // read pointer: plain advance, group loop or group exit
    if (consumed && !entered) begin
      s_d.rp = p1;
      pass_end = s_q.grp_act &&
                 ((p1 == s_q.grp_end) || (s_q.grp_frac && (p1 == (s_q.grp_start + `TTG_FRAC_HALF))));
    end
    if (pass_end) begin
      if (leave) begin
        // a newer command ends the group; see RULE6
        s_d.rp      = s_q.grp_end + `TTG_PTR_ONE;
        s_d.grp_act = 1'b0;
      end else if (!s_q.grp_frac) begin
        s_d.rp = s_q.grp_start;    // see RULE12
      end else begin
        frac_sel = 1'b1;
        ra_n     = s_q.half ? s_q.ra : s_q.ra - 8'h01;
        rb_n     = s_q.half ? s_q.rb - 8'h01 : s_q.rb;
      end
    end
    if (entered && !s_d.grp_frac) begin
      s_d.rp = s_d.grp_start;
    end
    if (frac_sel) begin
      // chunks of one sixteenth, exact totals per cycle; see RULE15, RULE16
      if ((ra_n == 8'h00) && (rb_n == 8'h00)) begin
        k_n  = find_chunk(k_n, fm1, fm2);
        ra_n = chunk_cnt(fm1, k_n);
        rb_n = chunk_cnt(fm2, k_n);
      end
      s_d.chunk = k_n;
      s_d.ra    = ra_n;
      s_d.rb    = rb_n;
      s_d.half  = (ra_n == 8'h00);
      s_d.rp    = (ra_n != 8'h00) ? s_d.grp_start : s_d.grp_start + `TTG_FRAC_HALF;
    end

    // retain a window of consumed entries for later groups
    if (!s_q.grp_act && ((s_q.rp - s_q.fp) > `TTG_GROUP_MAX)) begin
      s_d.fp = s_q.fp + `TTG_PTR_ONE;
    end
    s_d.data_ok = (s_d.rp == s_q.rp) && !(wr_ok && (s_q.wp == s_q.rp));
    if (soft_rst) begin
      s_d = GEN_RST;    // see RULE5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= GEN_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ----------------------------------------------------------------
// top: APB registers and two generators
// ----------------------------------------------------------------
module ttg_top
  import ttg_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // time engine
  input  wire logic [47:0] time_sec,
  input  wire logic [29:0] time_ns,
  input  wire logic [7:0]  time_frac,
  // generator outputs
  output logic             gen1_edge_out,
  output logic             gen2_edge_out
);

  ttg_top_s t_q;
  ttg_top_s t_d;
  logic     setup;
  logic     access;
  logic     mapped;
  logic     gen1_queue_full;
  logic     gen2_queue_full;
  logic     wr_q1;
  logic     wr_q2;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign mapped  = (paddr == `TTG_OFS_CTRL) || (paddr == `TTG_OFS_STAT) ||
                   (paddr == `TTG_OFS_QUE1) || (paddr == `TTG_OFS_QUE2);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = t_q.rdata;
  // one write-only port per queue; see RULE10
  assign wr_q1   = access && pwrite && (paddr == `TTG_OFS_QUE1);
  assign wr_q2   = access && pwrite && (paddr == `TTG_OFS_QUE2);

  always_comb begin
    t_d = t_q;
    if (access && pwrite && (paddr == `TTG_OFS_CTRL) && pstrb[0]) begin
      t_d.ctrl = pwdata[`TTG_CTRL_W-1:0];
    end
    if (setup) begin
      case (paddr)
        `TTG_OFS_CTRL: begin
          t_d.rdata = {26'h0000000, t_q.ctrl};
        end
        `TTG_OFS_STAT: begin
          t_d.rdata = {30'h00000000, gen2_queue_full, gen1_queue_full};    // see RULE8
        end
        default: begin
          t_d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q <= '{ctrl: `TTG_CTRL_RST, rdata: 32'h00000000};
    end else begin
      t_q <= t_d;
    end
  end

  // independent instances, own bits and queues; see RULE23
  ttg_gen u_gen1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_rst   (t_q.ctrl[`TTG_B_RST1]),
    .fine       (t_q.ctrl[`TTG_B_FINE1]),
    .adv_dis    (t_q.ctrl[`TTG_B_DIS1]),
    .wr_en      (wr_q1),
    .wr_data    (pwdata[`TTG_WORD_W-1:0]),
    .cur_sec    (time_sec),
    .cur_ns     (time_ns),
    .cur_frac   (time_frac),
    .queue_full (gen1_queue_full),
    .edge_out   (gen1_edge_out)
  );

  ttg_gen u_gen2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_rst   (t_q.ctrl[`TTG_B_RST2]),
    .fine       (t_q.ctrl[`TTG_B_FINE2]),
    .adv_dis    (t_q.ctrl[`TTG_B_DIS2]),
    .wr_en      (wr_q2),
    .wr_data    (pwdata[`TTG_WORD_W-1:0]),
    .cur_sec    (time_sec),
    .cur_ns     (time_ns),
    .cur_frac   (time_frac),
    .queue_full (gen2_queue_full),
    .edge_out   (gen2_edge_out)
  );

endmodule

// ==== dv/ttg_top_assertions.sv ====
// assertions on the ports of ttg_top
// assumes CTRL at 0x000, STAT at 0x004, queue ports at 0x008 and 0x00C
`timescale 1ns/1ps

module ttg_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // generator outputs
  input wire logic        gen1_edge_out,
  input wire logic        gen2_edge_out
);
  logic [5:0] ctrl_q;
  logic       rd;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign rd = psel && penable && !pwrite;

  // shadow of CTRL, taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 6'h00;
    end else if (psel && penable && pwrite && pstrb[0] && paddr == 12'h000) begin
      ctrl_q <= pwdata[5:0];
    end
  end

  a_gen1_rst_low: assert property (ctrl_q[2] && $past(ctrl_q[2]) |-> !gen1_edge_out)
    else $error("gen1 output high in reset");
  a_gen2_rst_low: assert property (ctrl_q[3] && $past(ctrl_q[3]) |-> !gen2_edge_out)
    else $error("gen2 output high in reset");
  a_rst_not_full: assert property (rd && paddr == 12'h004 && $past(ctrl_q[2], 3) && ctrl_q[2]
    |-> !prdata[0])
    else $error("gen1 full in reset");
  a_queue_wo: assert property (rd && paddr[11:3] == 9'h001 |-> prdata == 32'h0 && !pslverr)
    else $error("queue port readable");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
    else $error("unmapped access without error");
  a_ctrl_readback: assert property (rd && paddr == 12'h000 |-> prdata == {26'h0, ctrl_q})
    else $error("control read mismatch");
  a_stat_two_bits: assert property (rd && paddr == 12'h004 |-> prdata[31:2] == 30'h0)
    else $error("status upper bits set");
  a_gen1_spacing: assert property ($changed(gen1_edge_out) && !ctrl_q[2]
    |=> $stable(gen1_edge_out) || ctrl_q[2])
    else $error("gen1 edges too close");
  a_gen2_spacing: assert property ($changed(gen2_edge_out) && !ctrl_q[3]
    |=> $stable(gen2_edge_out) || ctrl_q[3])
    else $error("gen2 edges too close");

  c_gen1_edge: cover property ($rose(gen1_edge_out));
  c_gen2_edge: cover property ($fell(gen2_edge_out));
  c_slverr: cover property (pslverr);
endmodule

// ==== dv/ttg_top_tb_top.sv ====
// self-checking bench of the edge generator pair
// assumes ttg_pkg, ttg_top and ttg_checker are compiled first
`timescale 1ns/1ps

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

bind ttg_top ttg_checker i_ttg_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .gen1_edge_out(gen1_edge_out), .gen2_edge_out(gen2_edge_out));

module ttg_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        gen1_edge_out, gen2_edge_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [47:0] time_sec;
  logic [29:0] time_ns, t;
  logic [7:0]  time_frac;
  int          mismatches, samples_checked, c;

  ttg_top i_ttg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_sec(time_sec), .time_ns(time_ns), .time_frac(time_frac), .gen1_edge_out(gen1_edge_out),
    .gen2_edge_out(gen2_edge_out));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // time engine stand-in: 8 ns per clock
  always @(posedge pclk) time_ns <= time_ns + 30'h8;

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // cycles until the chosen output changes
  task automatic wait_edge(input int g, output int k);
    logic s;
    s = g ? gen2_edge_out : gen1_edge_out;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((g ? gen2_edge_out : gen1_edge_out) === s && k < 3000);
  endtask

  task automatic ten_toggles(input int g, output int s);
    int k;
    s = 0;
    wait_edge(g, k);
    for (int i = 0; i < 10; i++) begin
      wait_edge(g, k);
      s += k;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #150000;
    mismatches++;
    $display("unexpected run length: expected end seen timeout");
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {time_sec, time_ns, time_frac, mismatches, samples_checked} = '0;
    pstrb = 4'hF;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHK("ctrl reset", 32'h0, rd)
    wr(12'h000, 32'h30);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHK("ctrl back", 32'h30, rd)
    apb(1'b0, 12'h010, 32'h0, rd, err);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b0, 12'h008, 32'h0, rd, err);
    `CHK("queue port read", 32'h0, rd)
    $display("test registers done");
    // ----------------------------------------------------------------
    // gen1 25 MHz, gen2 absolute then relative
    // ----------------------------------------------------------------
    wr(12'h008, 32'h20000);
    wr(12'h008, 32'hF0014);
    wr(12'h008, 32'h00001);
    wr(12'h000, 32'h20);
    ten_toggles(0, c);
    `CHK("gen1 ten half periods", 25, c)
    `CHK("gen2 idle", 1'b0, gen2_edge_out)
    t = time_ns + 30'd800;
    repeat (3) wr(12'h00C, 32'h50000);
    wr(12'h00C, {16'h5, 2'b00, t[29:16]});
    wr(12'h00C, {16'h5, t[15:0]});
    wr(12'h00C, 32'hB0064);
    wr(12'h000, 32'h00);
    wait_edge(1, c);
    `CHK("gen2 rise", 1'b1, gen2_edge_out)
    `CHK("gen2 rise time", 1'b1, time_ns >= t + 30'd8 && time_ns <= t + 30'd16)
    wait_edge(1, c);
    `CHK("gen2 fall gap", 13, c)
    $display("test timing done");
    // ----------------------------------------------------------------
    // gen2 fine resolution, 20 ns half period
    // ----------------------------------------------------------------
    wr(12'h000, 32'h22);
    wr(12'h00C, 32'h20000);
    wr(12'h00C, 32'hF1400);
    wr(12'h00C, 32'h00001);
    wr(12'h000, 32'h02);
    ten_toggles(1, c);
    `CHK("gen2 fine half periods", 25, c)
    $display("test fine done");
    // ----------------------------------------------------------------
    // soft reset, advance-disable and queue full on gen1
    // ----------------------------------------------------------------
    wr(12'h000, 32'h06);
    repeat (3) @(posedge pclk);
    `CHK("gen1 reset low", 1'b0, gen1_edge_out)
    wr(12'h000, 32'h12);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 12'h004, 32'h0, rd, err);
      `CHK("stat before write", 2'b00, rd[1:0])
      wr(12'h008, 32'hF0010);
    end
    apb(1'b0, 12'h004, 32'h0, rd, err);
    `CHK("stat full", 2'b01, rd[1:0])
    `CHK("gen1 held", 1'b0, gen1_edge_out)
    wr(12'h000, 32'h16);
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    `CHK("stat after reset", 2'b00, rd[1:0])
    wr(12'h000, 32'h02);
    repeat (20) @(posedge pclk);
    `CHK("gen1 queue emptied", 1'b0, gen1_edge_out)
    $display("test queue done");
    // ----------------------------------------------------------------
    // gen1 32-bit relative step, then fractional repeat 2 and 1
    // ----------------------------------------------------------------
    wr(12'h000, 32'h12);
    wr(12'h008, 32'h20000);
    wr(12'h008, 32'hF0040);
    wr(12'h008, 32'hE0000);
    wr(12'h008, 32'hE0068);
    wr(12'h000, 32'h02);
    wait_edge(0, c);
    `CHK("gen1 rel32 first", 1'b1, gen1_edge_out)
    wait_edge(0, c);
    `CHK("gen1 rel32 gap", 13, c)
    wr(12'h000, 32'h12);
    wr(12'h008, 32'h20000);
    repeat (2) wr(12'h008, 32'hF0030);
    repeat (2) wr(12'h008, 32'hF0040);
    wr(12'h008, 32'h10201);
    wr(12'h000, 32'h02);
    ten_toggles(0, c);
    `CHK("gen1 fractional half periods", 68, c)
    $display("test relative done");
    end_of_test();
  end
endmodule
